// >>> hw/cpu_ctrl_defines.svh
// constants for the processor control and exception unit
// -----------------------------------------------------------------------------
// Summary of operation
// -----------------------------------------------------------------------------
`ifndef CPU_CTRL_DEFINES_SVH
`define CPU_CTRL_DEFINES_SVH
// -----------------------------------------------------------------------------
// memory map
// -----------------------------------------------------------------------------
`define RAM_LAST 16'h007f
`define VEC_MASKABLE 16'hfff8
`define VEC_NONMASK 16'hfffc
`define VEC_RESTART 16'hfffe
`define ADDR_HIGH_ONES 16'hff00
// -----------------------------------------------------------------------------
// flag layout
// -----------------------------------------------------------------------------
`define FLAG_MASK_BIT 4
`define FLAG_ONES 8'hc0
`define FLAG_RESET 8'hd0
`define SP_RESET 16'h00ff
// -----------------------------------------------------------------------------
// register bus map
// -----------------------------------------------------------------------------
`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_PC 8'h08
`define REG_SP 8'h0c
`define REG_IX 8'h10
`define REG_ACC 8'h14
`define REG_FLAGS 8'h18
`define REG_ACCESS 8'h1c
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// >>> hw/cpu_ctrl_pkg.sv
// types for the processor control and exception unit
package cpu_ctrl_pkg;
	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_VEC_HI = 4'h1,
		ST_VEC_LO = 4'h3,
		ST_RUN = 4'h2,
		ST_ACCESS = 4'h6,
		ST_PUSH = 4'h7,
		ST_HALT = 4'h5,
		ST_WAIT = 4'h4
	} cpu_state_t;
	typedef enum logic [1:0] {
		SRC_RESTART = 2'h0,
		SRC_MASKABLE = 2'h1,
		SRC_NONMASK = 2'h2
	} vec_src_t;
endpackage

// >>> hw/cpu_bus_control.sv
// processor bus control, halt, interrupt and restart sequencing
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cpu_ctrl_defines.svh"
module cpu_bus_control
	import cpu_ctrl_pkg::*;
#(
	parameter int RAM_WORDS = 128
)
(
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic E_CLOCK,
	input wire logic HALT_REQ_N,
	input wire logic IRQ_REQ_N,
	input wire logic NMI_REQ_N,
	input wire logic ONCHIP_RAM_SELECT,
	input wire logic [7:0] DATA_IN,
	output logic [7:0] DATA_OUT,
	output logic DATA_OE,
	output logic [15:0] ADDRESS,
	output logic READ_WRITE,
	output logic ADDRESS_VALID,
	output logic BUS_RELEASED,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// -------------------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------------------
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic e_prev;
	logic nmi_prev;
	always_ff @(posedge CLOCK)
	begin
		sync_a <= {E_CLOCK, HALT_REQ_N, IRQ_REQ_N, NMI_REQ_N};
		sync_b <= sync_a;
	end
	wire e_s = sync_b[3];
	wire halt_n = sync_b[2];
	wire irq_n = sync_b[1];
	wire nmi_n = sync_b[0];
	wire e_fall = e_prev & ~e_s;
	always_ff @(posedge CLOCK)
	begin
		e_prev <= e_s;
		nmi_prev <= e_s ? nmi_n : nmi_prev;
	end
	// -------------------------------------------------------------------------
	// programmer registers and state
	// -------------------------------------------------------------------------
	cpu_state_t state;
	vec_src_t vec_src;
	logic [15:0] program_counter;
	logic [15:0] stack_pointer;
	logic [15:0] index_register;
	logic [7:0] accumulator_first;
	logic [7:0] accumulator_second;
	logic [7:0] condition_flags;
	logic [2:0] push_step;
	logic irq_pend;
	logic nmi_pend;
	logic wait_req;
	logic access_req;
	logic access_write;
	logic [15:0] access_addr;
	logic [7:0] access_data;
	logic [7:0] read_data;
	logic [7:0] ram [RAM_WORDS];
	wire irq_take = irq_pend & ~condition_flags[`FLAG_MASK_BIT];
	wire int_take = nmi_pend | irq_take;
	wire in_ram = access_addr <= `RAM_LAST;
	wire ram_hit = in_ram & ONCHIP_RAM_SELECT;
	// host write decode
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	wire wr_go = aw_held & w_held & ~S_AXI_BVALID;
	// -------------------------------------------------------------------------
	// interrupt latches
	// -------------------------------------------------------------------------
	// non-maskable requests latch even while halted so they are served after the stop; the maskable request follows its pin
	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
			nmi_pend <= 1'b0;
		else if (e_s && nmi_prev && !nmi_n)
			nmi_pend <= 1'b1;
		else if (state == ST_PUSH && push_step == 3'h6 && e_fall
			&& vec_src == SRC_NONMASK)
			nmi_pend <= 1'b0;
	end
	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
			irq_pend <= 1'b0;
		else if (e_s)
			irq_pend <= ~irq_n;
	end
	// -------------------------------------------------------------------------
	// sequencer
	// -------------------------------------------------------------------------
	// each bus step completes on a falling edge of the E clock
	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			state <= ST_RESET;
			vec_src <= SRC_RESTART;
			program_counter <= `VEC_RESTART;
			stack_pointer <= `SP_RESET;
			index_register <= 16'h0000;
			accumulator_first <= 8'h00;
			accumulator_second <= 8'h00;
			condition_flags <= `FLAG_RESET;
			push_step <= 3'h0;
			read_data <= 8'h00;
		end
		else
		begin
			if (wr_go)
			begin
				case (aw_addr)
				`REG_PC: program_counter <= w_data[15:0];
				`REG_SP: stack_pointer <= w_data[15:0];
				`REG_IX: index_register <= w_data[15:0];
				`REG_ACC:
				begin
					accumulator_first <= w_data[7:0];
					accumulator_second <= w_data[15:8];
				end
				`REG_FLAGS: condition_flags <= w_data[7:0] | `FLAG_ONES;
				default: ;
				endcase
			end
			if (e_fall)
			begin
				case (state)
				ST_RESET:
				begin
					condition_flags[`FLAG_MASK_BIT] <= 1'b1;
					state <= ST_VEC_HI;
				end
				ST_VEC_HI:
				begin
					program_counter[15:8] <= DATA_IN;
					state <= ST_VEC_LO;
				end
				ST_VEC_LO:
				begin
					program_counter[7:0] <= DATA_IN;
					state <= ST_RUN;
				end
				ST_RUN:
				begin
					// instruction boundary
					if (!halt_n)
						state <= ST_HALT;
					else if (int_take)
					begin
						vec_src <= nmi_pend ? SRC_NONMASK : SRC_MASKABLE;
						push_step <= 3'h0;
						state <= ST_PUSH;
					end
					else if (wait_req)
						state <= ST_WAIT;
					else if (access_req)
						state <= ST_ACCESS;
				end
				ST_ACCESS:
				begin
					if (!access_write)
						read_data <= ram_hit ? ram[access_addr[6:0]] : DATA_IN;
					state <= ST_RUN;
				end
				ST_PUSH:
				begin
					stack_pointer <= stack_pointer - 16'h0001;
					push_step <= push_step + 3'h1;
					if (push_step == 3'h6)
					begin
						if (vec_src == SRC_MASKABLE)
							condition_flags[`FLAG_MASK_BIT] <= 1'b1;
						state <= ST_VEC_HI;
					end
				end
				ST_HALT:
					if (halt_n)
						state <= ST_RUN;
				ST_WAIT:
					if (int_take && halt_n)
					begin
						vec_src <= nmi_pend ? SRC_NONMASK : SRC_MASKABLE;
						push_step <= 3'h0;
						state <= ST_PUSH;
					end
				default: state <= ST_RESET;
				endcase
			end
		end
	end
	// -------------------------------------------------------------------------
	// bus outputs
	// -------------------------------------------------------------------------
	logic [7:0] push_byte;
	logic [15:0] vec_base;
	always_comb
	begin
		case (push_step)
		3'h0: push_byte = program_counter[7:0];
		3'h1: push_byte = program_counter[15:8];
		3'h2: push_byte = index_register[7:0];
		3'h3: push_byte = index_register[15:8];
		3'h4: push_byte = accumulator_first;
		3'h5: push_byte = accumulator_second;
		default: push_byte = condition_flags | `FLAG_ONES;
		endcase
		case (vec_src)
		SRC_MASKABLE: vec_base = `VEC_MASKABLE;
		SRC_NONMASK: vec_base = `VEC_NONMASK;
		default: vec_base = `VEC_RESTART;
		endcase
	end
	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			ADDRESS <= `ADDR_HIGH_ONES;
			READ_WRITE <= 1'b1;
			ADDRESS_VALID <= 1'b0;
			BUS_RELEASED <= 1'b0;
			DATA_OE <= 1'b0;
			DATA_OUT <= 8'h00;
		end
		else
		begin
			BUS_RELEASED <= state == ST_HALT || state == ST_WAIT;
			case (state)
			ST_VEC_HI, ST_VEC_LO:
			begin
				ADDRESS <= vec_base | {15'h0000, state == ST_VEC_LO};
				READ_WRITE <= 1'b1;
				ADDRESS_VALID <= 1'b1;
				DATA_OE <= 1'b0;
			end
			ST_PUSH:
			begin
				ADDRESS <= stack_pointer;
				READ_WRITE <= 1'b0;
				ADDRESS_VALID <= 1'b1;
				DATA_OE <= 1'b1;
				DATA_OUT <= push_byte;
			end
			ST_ACCESS:
			begin
				ADDRESS <= access_addr;
				READ_WRITE <= ~access_write;
				ADDRESS_VALID <= 1'b1;
				// internal RAM reads drive the bus to block outside data
				DATA_OE <= access_write | ram_hit;
				DATA_OUT <= (ram_hit && !access_write)
					? ram[access_addr[6:0]] : access_data;
			end
			default:
			begin
				// idle, stopped or in reset: address shows next instruction (ff00 in reset), drivers off
				ADDRESS <= state == ST_RESET ? `ADDR_HIGH_ONES
					: program_counter;
				READ_WRITE <= 1'b1;
				ADDRESS_VALID <= 1'b0;
				DATA_OE <= 1'b0;
			end
			endcase
		end
	end
	// on-chip RAM holds no reset; contents survive a restart
	always_ff @(posedge CLOCK)
	begin
		if (e_fall && state == ST_ACCESS && access_write && ram_hit)
			ram[access_addr[6:0]] <= access_data;
	end
	// -------------------------------------------------------------------------
	// register bus slave
	// -------------------------------------------------------------------------
	assign S_AXI_AWREADY = ~aw_held;
	assign S_AXI_WREADY = ~w_held;
	assign S_AXI_ARREADY = ~S_AXI_RVALID;
	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `AXI_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID && !aw_held)
			begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_held)
			begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
			end
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= aw_addr > `REG_ACCESS ? `AXI_SLVERR : `AXI_OKAY;
			end
			else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end
	// control register: bit0 request access, bit1 write, bit2 wait
	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			access_req <= 1'b0;
			access_write <= 1'b0;
			access_addr <= 16'h0000;
			access_data <= 8'h00;
			wait_req <= 1'b0;
		end
		else
		begin
			if (wr_go && aw_addr == `REG_CONTROL)
			begin
				access_req <= w_data[0];
				access_write <= w_data[1];
				wait_req <= w_data[2];
			end
			else if (wr_go && aw_addr == `REG_ACCESS)
			begin
				access_addr <= w_data[15:0];
				access_data <= w_data[23:16];
			end
			else if (e_fall && state == ST_ACCESS)
				access_req <= 1'b0;
			else if (e_fall && state == ST_RUN && wait_req && halt_n
				&& !int_take)
				wait_req <= 1'b0;
		end
	end
	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `AXI_OKAY;
		end
		else if (S_AXI_ARVALID && !S_AXI_RVALID)
		begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= `AXI_OKAY;
			case (S_AXI_ARADDR)
			`REG_CONTROL: S_AXI_RDATA <= {29'h0, wait_req, access_write,
				access_req};
			`REG_STATUS: S_AXI_RDATA <= {16'h0, read_data, 2'h0, nmi_pend,
				irq_pend, state};
			`REG_PC: S_AXI_RDATA <= {16'h0, program_counter};
			`REG_SP: S_AXI_RDATA <= {16'h0, stack_pointer};
			`REG_IX: S_AXI_RDATA <= {16'h0, index_register};
			`REG_ACC: S_AXI_RDATA <= {16'h0, accumulator_second,
				accumulator_first};
			`REG_FLAGS: S_AXI_RDATA <= {24'h0, condition_flags | `FLAG_ONES};
			`REG_ACCESS: S_AXI_RDATA <= {8'h0, access_data, access_addr};
			default:
			begin
				S_AXI_RDATA <= 32'h00000000;
				S_AXI_RRESP <= `AXI_SLVERR;
			end
			endcase
		end
		else if (S_AXI_RREADY)
			S_AXI_RVALID <= 1'b0;
	end
endmodule

// >>> verif/cpu_bus_control_sva.sv
// assertions on the processor bus control pins
`timescale 1ns/1ps
module cpu_bus_control_sva (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic HALT_REQ_N,
	input wire logic ONCHIP_RAM_SELECT,
	input wire logic DATA_OE,
	input wire logic [15:0] ADDRESS,
	input wire logic READ_WRITE,
	input wire logic ADDRESS_VALID,
	input wire logic BUS_RELEASED
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	sequence s_halt_held;
		!HALT_REQ_N [*8];
	endsequence
	sequence s_restart_fetch;
		ADDRESS == 16'hfffe && ADDRESS_VALID && READ_WRITE;
	endsequence
	property p_quiet;
		BUS_RELEASED |-> !ADDRESS_VALID && READ_WRITE && !DATA_OE;
	endproperty
	property p_idle_read;
		!ADDRESS_VALID |-> READ_WRITE;
	endproperty
	// select is not synced, so only a settled select is judged
	property p_ram_out;
		ADDRESS_VALID && ADDRESS <= 16'h007f && ONCHIP_RAM_SELECT
			&& $stable(ONCHIP_RAM_SELECT) |-> DATA_OE;
	endproperty
	property p_reset_out;
		disable iff (1'b0) !RESET_N |=> ADDRESS == 16'hff00
			&& !ADDRESS_VALID && !BUS_RELEASED && READ_WRITE;
	endproperty
	property p_restart;
		$rose(RESET_N) |-> ##[1:200] s_restart_fetch;
	endproperty
	property p_halt_stop;
		$fell(HALT_REQ_N) |-> ##[1:400] (BUS_RELEASED || HALT_REQ_N);
	endproperty
	property p_halt_hold;
		s_halt_held ##0 BUS_RELEASED |=> BUS_RELEASED;
	endproperty
	property p_step_addr;
		$rose(ADDRESS_VALID) |=> $stable(ADDRESS) [*4];
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("bus active while released");
	a_idle_read: assert property (p_idle_read)
		else $error("write strobe without valid address");
	a_ram_out: assert property (p_ram_out)
		else $error("data bus not driven on ram access");
	a_reset_out: assert property (p_reset_out)
		else $error("outputs not inactive in reset");
	a_restart: assert property (p_restart)
		else $error("restart vector not fetched");
	a_halt_stop: assert property (p_halt_stop)
		else $error("stop request not obeyed");
	a_halt_hold: assert property (p_halt_hold)
		else $error("left stop while request low");
	a_step_addr: assert property (p_step_addr)
		else $error("address moved inside a step");
endmodule
bind cpu_bus_control cpu_bus_control_sva cpu_bus_control_sva_i (
	.CLOCK(CLOCK), .RESET_N(RESET_N), .HALT_REQ_N(HALT_REQ_N),
	.ONCHIP_RAM_SELECT(ONCHIP_RAM_SELECT), .DATA_OE(DATA_OE),
	.ADDRESS(ADDRESS), .READ_WRITE(READ_WRITE),
	.ADDRESS_VALID(ADDRESS_VALID), .BUS_RELEASED(BUS_RELEASED));

// >>> verif/bus_memory_model.sv
// external memory on the far side of the processor bus
`timescale 1ns/1ps
module bus_memory_model (
	input wire logic clock,
	input wire logic [15:0] address,
	input wire logic read_write,
	input wire logic address_valid,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic ram_select,
	output logic [7:0] data_in
);
	logic [7:0] mem [0:65535];
	logic [7:0] last;
	logic own;
	logic drive;
	// keeps off the bus in the on-chip range while that ram is on
	assign own = !(ram_select && address <= 16'h007f);
	assign drive = own && address_valid && read_write;
	// a released bus toggles so a stale byte never passes for data
	assign data_in = drive ? mem[address] : last;
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i) ^ 8'(i >> 8);
		last = 8'h00;
	end
	always @(posedge clock)
	begin
		last <= ~data_in;
		if (own && address_valid && !read_write && data_oe)
			mem[address] <= data_out;
	end
endmodule

// >>> verif/cpu_bus_control_and_exceptions_bench.sv
// self-checking bench for the processor bus control block
`timescale 1ns/1ps
`include "cpu_ctrl_defines.svh"
module cpu_bus_control_and_exceptions_bench;
	logic clock = 0, reset_n = 0, e_clock = 0, halt_n = 1, irq_n = 1;
	logic nmi_n = 1, sel = 1, awv = 0, wv = 0, bready = 0;
	logic arv = 0, rready = 0;
	logic [7:0] din, dout, awaddr = 0, araddr = 0, acc_a, acc_b, d;
	logic oe, rw, av, br, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rr;
	logic [15:0] address, pc, sp, ix;
	logic [31:0] wdata = 0, rdata, rd, seed = 32'hdb48;
	int num_errors = 0, samples_checked = 0;
	always #2.5 clock = ~clock;
	always #41 e_clock = ~e_clock;
	cpu_bus_control cpu_bus_control_i (.CLOCK(clock), .RESET_N(reset_n),
		.E_CLOCK(e_clock), .HALT_REQ_N(halt_n), .IRQ_REQ_N(irq_n),
		.NMI_REQ_N(nmi_n), .ONCHIP_RAM_SELECT(sel), .DATA_IN(din),
		.DATA_OUT(dout), .DATA_OE(oe), .ADDRESS(address),
		.READ_WRITE(rw), .ADDRESS_VALID(av), .BUS_RELEASED(br),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	bus_memory_model bus_memory_model_i (.clock(clock),
		.address(address), .read_write(rw), .address_valid(av),
		.data_out(dout), .data_oe(oe), .ram_select(sel), .data_in(din));
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8];
	endfunction
	function automatic logic [15:0] mv(input logic [15:0] a);
		return {pat(a), pat(a + 16'h1)};
	endfunction
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= v;
		awv <= 1;
		wv <= 1;
		bready <= 1;
		do
		begin
			@(posedge clock);
			if (awready) awv <= 0;
			if (wready) wv <= 0;
			n++;
		end
		while (bvalid !== 1'b1 && n < 200);
		bready <= 0;
		chk("write_resp", `AXI_OKAY, bresp);
		if (n >= 200) num_errors++;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clock);
		araddr <= a;
		arv <= 1;
		rready <= 1;
		do
		begin
			@(posedge clock);
			if (arready) arv <= 0;
			n++;
		end
		while (rvalid !== 1'b1 && n < 200);
		v = rdata;
		r = rresp;
		rready <= 0;
		if (n >= 200) num_errors++;
	endtask
	// polls the counter, so the wait does not assume a step length
	task automatic wpc(input logic [15:0] e);
		int n;
		n = 0;
		do
		begin
			rdr(`REG_PC, rd, rr);
			n++;
		end
		while (rd[15:0] !== e && n < 300);
		chk("program_counter", e, rd[15:0]);
	endtask
	task automatic wbr();
		int n;
		for (n = 0; br !== 1'b1 && n < 500; n++)
			@(posedge clock);
		chk("bus_released", 1, br);
	endtask
	task automatic wav();
		int n;
		for (n = 0; av !== 1'b1 && n < 500; n++)
			@(posedge clock);
		for (n = n; av !== 1'b0 && n < 1000; n++)
			@(posedge clock);
		if (n >= 500) num_errors++;
	endtask
	task automatic stk(input logic [7:0] fl);
		logic [7:0] q [$];
		q = '{pc[7:0], pc[15:8], ix[7:0], ix[15:8], acc_a, acc_b, fl};
		foreach (q[i])
			chk("stack_byte", q[i], bus_memory_model_i.mem[sp - 16'(i)]);
		sp = sp - 16'h7;
		rdr(`REG_SP, rd, rr);
		chk("stack_pointer", sp, rd[15:0]);
	endtask
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#300000;
		num_errors++;
		summarize();
	end
	initial
	begin
		repeat (4) @(posedge clock);
		reset_n <= 1;
		wpc(mv(16'hfffe));
		rdr(`REG_FLAGS, rd, rr);
		chk("flags", 8'hd0, rd[7:0] & 8'hd0);
		$display("restart test done");
		sp = `SP_RESET;
		rd = xs();
		{ix, acc_a, acc_b} = rd;
		rd = xs();
		pc = rd[15:0];
		wr(`REG_PC, {16'h0, pc});
		wr(`REG_IX, {16'h0, ix});
		wr(`REG_ACC, {16'h0, acc_b, acc_a});
		rdr(`REG_ACC, rd, rr);
		chk("accumulators", {acc_b, acc_a}, rd[15:0]);
		rdr(`REG_IX, rd, rr);
		chk("index_register", ix, rd[15:0]);
		irq_n <= 0;
		wr(`REG_CONTROL, 32'h4);
		wbr();
		wr(`REG_CONTROL, 32'h0);
		repeat (64) @(posedge clock);
		rdr(`REG_PC, rd, rr);
		chk("masked_pc", pc, rd[15:0]);
		wr(`REG_FLAGS, 32'h0);
		wpc(mv(16'hfff8));
		irq_n <= 1;
		stk(8'hc0);
		rdr(`REG_FLAGS, rd, rr);
		chk("mask", 8'h10, rd[7:0] & 8'h10);
		pc = mv(16'hfff8);
		$display("maskable test done");
		halt_n <= 0;
		wbr();
		chk("address", pc, address);
		nmi_n <= 0;
		repeat (64) @(posedge clock);
		rdr(`REG_PC, rd, rr);
		chk("halted_pc", pc, rd[15:0]);
		halt_n <= 1;
		nmi_n <= 1;
		wpc(mv(16'hfffc));
		stk(8'hd0);
		$display("halt and non-maskable test done");
		rd = xs();
		d = rd[7:0];
		wr(`REG_ACCESS, {8'h0, d, 16'h0010});
		wr(`REG_CONTROL, 32'h3);
		wav();
		wr(`REG_CONTROL, 32'h1);
		wav();
		rdr(`REG_STATUS, rd, rr);
		chk("ram_byte", d, rd[15:8]);
		sel <= 0;
		wr(`REG_CONTROL, 32'h1);
		wav();
		rdr(`REG_STATUS, rd, rr);
		chk("outside_byte", pat(16'h0010), rd[15:8]);
		rdr(8'h20, rd, rr);
		chk("unmapped_resp", `AXI_SLVERR, rr);
		chk("unmapped_data", 0, rd);
		$display("ram select test done");
		summarize();
	end
endmodule
